//--- mppc_map.vh
// register map, field widths and reset values of the motor port pin control
`ifndef MPPC_MAP_VH
`define MPPC_MAP_VH
`define MPPC_T_DRIVE_STRENGTH 8'h00
`define MPPC_T_PULL_ENABLE 8'h04
`define MPPC_T_PULL_POLARITY 8'h08
`define MPPC_U_DATA 8'h0c
`define MPPC_U_PIN_LEVEL 8'h10
`define MPPC_U_DIRECTION 8'h14
`define MPPC_U_SLEW_LIMIT 8'h18
`define MPPC_U_PULL_ENABLE 8'h1c
`define MPPC_U_PULL_POLARITY 8'h20
`define MPPC_T_DIRECTION 8'h24
`define MPPC_ADDR_W 8
`define MPPC_RST_BYTE 8'h00
`define MPPC_SYNC_STAGES 2
`endif

//--- mppc_port.v
// register file and pad control for the motor port pin control block
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// R1: first-port drive bit 0 gives full drive, 1 about one third drive.
// R2: drive-strength bit is ignored while its pin is an input.
// R3: pull-enable bit turns pull on only for input pins.
// R4: polarity 0 pull-up, 1 pull-down; needs direction 0 and pull on.
// R5: second-port owner priority: stall detector, motor pwm, then gpio.
// R6: upper stall detector owns upper four pins, else pwm channels 3,2.
// R7: lower stall detector owns lower four pins, else pwm channels 1,0.
// R8: in reset all second-port pins are inputs without pulls.
// R9: data read returns stored bit when direction bit is 1.
// R10: input pin data read gives 1 if slew limited, else pin level.
// R11: pin-level register is read only; 1 if slew limited, else pin.
// R12: enabled stall detector or pwm forces output, direction ignored.
// R13: direction bit 0 input, 1 output under gpio control.
// R14: slew bit 1 limits slew and turns off the input buffer.
// R15: third port: upper pins to third detector, else pwm 7,6.
// R16: lower third-port pins to second detector, else pwm 5,4.
// R17: in reset all third-port pins are high-impedance inputs.
// R18: software may access registers anytime, pin-level is read only.
// R19: reads follow a direction change within two bus cycles.
// R20: pin levels pass a two-stage synchroniser; enables are inputs.
`include "mppc_map.vh"
module mppc_port #(
    parameter WIDTH = 8
) (
    input wire clk,
    input wire rst_n,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [`MPPC_ADDR_W-1:0] wb_adr_i,
    input wire [31:0] wb_dat_i,
    input wire [3:0] wb_sel_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    input wire [3:0] stall_detector_en,
    input wire [7:0] motor_pwm_en,
    input wire [WIDTH-1:0] u_pwm_out,
    input wire [WIDTH-1:0] u_stall_out,
    input wire [WIDTH-1:0] v_pwm_out,
    input wire [WIDTH-1:0] v_stall_out,
    input wire [WIDTH-1:0] t_pads_i,
    output reg [WIDTH-1:0] t_reduced_drive,
    output reg [WIDTH-1:0] t_pull_on,
    output reg [WIDTH-1:0] t_pull_down,
    input wire [WIDTH-1:0] u_pads_i,
    output reg [WIDTH-1:0] u_pads_o,
    output reg [WIDTH-1:0] u_pads_oe,
    output reg [WIDTH-1:0] u_pull_on,
    output reg [WIDTH-1:0] u_pull_down,
    output reg [WIDTH-1:0] u_slew_on,
    output reg [WIDTH-1:0] u_inbuf_en,
    output reg [WIDTH-1:0] v_pads_o,
    output reg [WIDTH-1:0] v_pads_oe,
    output reg [WIDTH-1:0] v_pull_on
);
// ----------------------------------------------------------------
// registers
// ----------------------------------------------------------------
reg [WIDTH-1:0] t_drive_strength;
reg [WIDTH-1:0] t_pull_enable;
reg [WIDTH-1:0] t_pull_polarity;
reg [WIDTH-1:0] t_direction;
reg [WIDTH-1:0] u_data;
reg [WIDTH-1:0] u_direction;
reg [WIDTH-1:0] u_slew_limit;
reg [WIDTH-1:0] u_pull_enable;
reg [WIDTH-1:0] u_pull_polarity;
reg [WIDTH-1:0] u_sync1;
reg [WIDTH-1:0] u_sync2;
wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
wire wr = req & wb_we_i & wb_sel_i[0];
wire [WIDTH-1:0] wd = wb_dat_i[WIDTH-1:0];
// ----------------------------------------------------------------
// ownership: detector beats pwm beats gpio
// ----------------------------------------------------------------
wire [WIDTH-1:0] u_det;
wire [WIDTH-1:0] u_pwm;
wire [WIDTH-1:0] v_det;
wire [WIDTH-1:0] v_pwm;
assign u_det = {{4{stall_detector_en[1]}}, {4{stall_detector_en[0]}}};
assign v_det = {{4{stall_detector_en[3]}}, {4{stall_detector_en[2]}}};
// each pwm channel owns two pins
assign u_pwm = ~u_det & {{2{motor_pwm_en[3]}}, {2{motor_pwm_en[2]}},
    {2{motor_pwm_en[1]}}, {2{motor_pwm_en[0]}}}; // R6 R7
assign v_pwm = ~v_det & {{2{motor_pwm_en[7]}}, {2{motor_pwm_en[6]}},
    {2{motor_pwm_en[5]}}, {2{motor_pwm_en[4]}}}; // R15 R16
wire [WIDTH-1:0] u_out_dir = u_det | u_pwm | u_direction; // R12 R13
wire [WIDTH-1:0] u_level = u_slew_limit | u_sync2; // R11 R14
reg [WIDTH-1:0] next_u_pads_o;
reg [WIDTH-1:0] next_v_pads_o;
integer i;
always @* begin
    for (i = 0; i < WIDTH; i = i + 1) begin
        if (u_det[i]) begin
            next_u_pads_o[i] = u_stall_out[i]; // R5
        end else if (u_pwm[i]) begin
            next_u_pads_o[i] = u_pwm_out[i];
        end else begin
            next_u_pads_o[i] = u_data[i];
        end
        if (v_det[i]) begin
            next_v_pads_o[i] = v_stall_out[i]; // R15
        end else begin
            next_v_pads_o[i] = v_pwm_out[i];
        end
    end
end
// ----------------------------------------------------------------
// read mux
// ----------------------------------------------------------------
reg [WIDTH-1:0] rd;
always @* begin
    case (wb_adr_i)
        `MPPC_T_DRIVE_STRENGTH: rd = t_drive_strength;
        `MPPC_T_PULL_ENABLE: rd = t_pull_enable;
        `MPPC_T_PULL_POLARITY: rd = t_pull_polarity;
        `MPPC_T_DIRECTION: rd = t_direction;
        // R9 R10
        `MPPC_U_DATA: rd = (u_direction & u_data) | (~u_direction & u_level);
        `MPPC_U_PIN_LEVEL: rd = u_level; // R11
        `MPPC_U_DIRECTION: rd = u_direction;
        `MPPC_U_SLEW_LIMIT: rd = u_slew_limit;
        `MPPC_U_PULL_ENABLE: rd = u_pull_enable;
        `MPPC_U_PULL_POLARITY: rd = u_pull_polarity;
        default: rd = {WIDTH{1'b0}};
    endcase
end
// ----------------------------------------------------------------
// bus slave and config registers
// ----------------------------------------------------------------
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        wb_ack_o <= 1'b0;
        wb_dat_o <= 32'h0000_0000;
        t_drive_strength <= `MPPC_RST_BYTE;
        t_pull_enable <= `MPPC_RST_BYTE;
        t_pull_polarity <= `MPPC_RST_BYTE;
        t_direction <= `MPPC_RST_BYTE;
        u_data <= `MPPC_RST_BYTE;
        u_direction <= `MPPC_RST_BYTE;
        u_slew_limit <= `MPPC_RST_BYTE;
        u_pull_enable <= `MPPC_RST_BYTE;
        u_pull_polarity <= `MPPC_RST_BYTE;
    end else begin
        wb_ack_o <= req;
        wb_dat_o <= req ? {{(32-WIDTH){1'b0}}, rd} : 32'h0000_0000;
        if (wr) begin
            case (wb_adr_i)
                `MPPC_T_DRIVE_STRENGTH: t_drive_strength <= wd;
                `MPPC_T_PULL_ENABLE: t_pull_enable <= wd;
                `MPPC_T_PULL_POLARITY: t_pull_polarity <= wd;
                `MPPC_T_DIRECTION: t_direction <= wd;
                `MPPC_U_DATA: u_data <= wd;
                `MPPC_U_DIRECTION: u_direction <= wd;
                `MPPC_U_SLEW_LIMIT: u_slew_limit <= wd;
                `MPPC_U_PULL_ENABLE: u_pull_enable <= wd;
                `MPPC_U_PULL_POLARITY: u_pull_polarity <= wd;
                default: u_data <= u_data; // pin-level write ignored
            endcase
        end
    end
end
// ----------------------------------------------------------------
// pin synchroniser and pad drive
// ----------------------------------------------------------------
// buffer off while slew limited, so the gated level never toggles
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        u_sync1 <= `MPPC_RST_BYTE;
        u_sync2 <= `MPPC_RST_BYTE;
    end else begin
        u_sync1 <= u_pads_i & ~u_slew_limit; // R20
        u_sync2 <= u_sync1; // R19
    end
end
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        u_pads_o <= `MPPC_RST_BYTE;
        u_pads_oe <= `MPPC_RST_BYTE; // R8
        u_pull_on <= `MPPC_RST_BYTE;
        u_pull_down <= `MPPC_RST_BYTE;
        u_slew_on <= `MPPC_RST_BYTE;
        u_inbuf_en <= {WIDTH{1'b1}};
        v_pads_o <= `MPPC_RST_BYTE;
        v_pads_oe <= `MPPC_RST_BYTE; // R17
        v_pull_on <= `MPPC_RST_BYTE;
        t_reduced_drive <= `MPPC_RST_BYTE;
        t_pull_on <= `MPPC_RST_BYTE;
        t_pull_down <= `MPPC_RST_BYTE;
    end else begin
        u_pads_o <= next_u_pads_o;
        u_pads_oe <= u_out_dir;
        u_pull_on <= u_pull_enable & ~u_out_dir; // R3
        u_pull_down <= u_pull_polarity & u_pull_enable & ~u_out_dir; // R4
        u_slew_on <= u_slew_limit; // R14
        u_inbuf_en <= ~u_slew_limit;
        v_pads_o <= next_v_pads_o;
        v_pads_oe <= v_det | v_pwm; // R15 R16
        v_pull_on <= `MPPC_RST_BYTE;
        t_reduced_drive <= t_drive_strength & t_direction; // R1 R2
        t_pull_on <= t_pull_enable & ~t_direction; // R3
        t_pull_down <= t_pull_polarity & t_pull_enable & ~t_direction; // R4
    end
end
endmodule
`default_nettype wire

//--- mppc_port_chk.sv
// port assertions of the motor port pin control
`timescale 1ns/1ns
`default_nettype none
module mppc_port_chk (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [3:0] stall_detector_en,
    input wire logic [7:0] motor_pwm_en,
    input wire logic [7:0] u_pwm_out,
    input wire logic [7:0] u_stall_out,
    input wire logic [7:0] u_pads_o,
    input wire logic [7:0] u_pads_oe,
    input wire logic [7:0] u_pull_on,
    input wire logic [7:0] u_slew_on,
    input wire logic [7:0] u_inbuf_en,
    input wire logic [7:0] v_pads_oe,
    input wire logic [7:0] v_pull_on
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_ack_take: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
        |=> wb_ack_o) else $error("no ack");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    a_low_stall: assert property (stall_detector_en[0] |=>
        u_pads_oe[3:0] == 4'hf && u_pads_o[3:0] == $past(u_stall_out[3:0]))
        else $error("lower stall owner");
    a_up_stall: assert property (stall_detector_en[1] |=>
        u_pads_oe[7:4] == 4'hf && u_pads_o[7:4] == $past(u_stall_out[7:4]))
        else $error("upper stall owner");
    a_pwm_own: assert property (!stall_detector_en[0] && motor_pwm_en[0]
        |=> u_pads_oe[1:0] == 2'h3 && u_pads_o[1:0] == $past(u_pwm_out[1:0]))
        else $error("pwm owner");
    a_pull_out: assert property ((u_pull_on & u_pads_oe) == 8'h0)
        else $error("pull on driven pin");
    a_slew_buf: assert property (u_inbuf_en == ~u_slew_on)
        else $error("input buffer vs slew");
    a_reset_hiz: assert property (@(posedge clk) disable iff (1'b0)
        !rst_n |-> (u_pads_oe | u_pull_on | v_pads_oe | v_pull_on) == 8'h0)
        else $error("pins not idle in reset");
endmodule
bind mppc_port mppc_port_chk i_chk (.*);
`default_nettype wire

//--- mppc_pads.sv
// second-port pads with an external load
`timescale 1ns/1ns
`default_nettype none
module mppc_pads (
    input wire logic clk,
    input wire logic [7:0] d,
    input wire logic [7:0] oe,
    input wire logic [7:0] pu,
    input wire logic [7:0] pd,
    input wire logic [7:0] x,
    input wire logic [7:0] xe,
    output logic [7:0] pin
);
    // floating pins wander, so a stale level never passes
    logic [7:0] drift = 8'h0;
    always @(posedge clk) drift <= drift + 8'h1;
    assign pin = oe & d | ~oe & (xe & x | ~xe & (pu & ~pd | ~pu & drift));
endmodule
`default_nettype wire

//--- mppc_port_test.sv
// self-checking bench for the motor port pin control
`timescale 1ns/1ns
`default_nettype none
`include "mppc_map.vh"
`define CK(n, e, g) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
    $display("FAIL %s exp %h got %h", n, e, g); end end
module mppc_port_test;
    logic clk = 0, rst_n = 1, cyc = 0, stb = 0, we = 0, ack;
    logic [7:0] adr = 0, q, ext = 0, xe = 8'hff, up = 0, us = 0, vp = 0;
    logic [7:0] vs = 0, pwm = 0, uo, uoe, upo, upd, usl, uib, vo, voe, tr;
    logic [7:0] tpo, tpd, ui, vpu;
    logic [3:0] sd = 0, sel = 4'h1;
    logic [31:0] wd = 0, rd;
    int mismatches = 0, n_tests = 0, cycles = 0;
    always #5 clk = ~clk;
    mppc_port i_dut (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wd), .wb_sel_i(sel),
        .wb_dat_o(rd), .wb_ack_o(ack), .stall_detector_en(sd),
        .motor_pwm_en(pwm), .u_pwm_out(up), .u_stall_out(us), .v_pwm_out(vp),
        .v_stall_out(vs), .t_pads_i(8'h0), .t_reduced_drive(tr),
        .t_pull_on(tpo), .t_pull_down(tpd), .u_pads_i(ui), .u_pads_o(uo),
        .u_pads_oe(uoe), .u_pull_on(upo), .u_pull_down(upd), .u_slew_on(usl),
        .u_inbuf_en(uib), .v_pads_o(vo), .v_pads_oe(voe), .v_pull_on(vpu));
    mppc_pads i_pads (.clk(clk), .d(uo), .oe(uoe), .pu(upo), .pd(upd),
        .x(ext), .xe(xe), .pin(ui));
    task automatic wb(input [7:0] a, input w, input [7:0] d);
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= a;
        wd <= {24'h0, d};
        @(posedge clk iff ack);
        q = rd[7:0];
        cyc <= 0;
        stb <= 0;
        @(posedge clk);
    endtask
    task automatic rdc(input [7:0] a, input [7:0] e, input string n);
        wb(a, 0, 8'h0);
        `CK(n, e, q)
    endtask
    task automatic results;
        $display("mismatches %0d n_tests %0d", mismatches, n_tests);
        if (mismatches == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            results();
        end
    end
    initial begin
        rst_n <= 1'b0;
        repeat (10) @(posedge clk);
        `CK("u oe rst", 8'h0, uoe)
        `CK("u pull rst", 8'h0, upo)
        `CK("v pull rst", 8'h0, vpu)
        `CK("v oe rst", 8'h0, voe)
        rst_n <= 1;
        @(posedge clk);
        rdc(`MPPC_U_DATA, 8'h0, "data rst");
        wb(`MPPC_U_DIRECTION, 1, 8'h0f);
        ext <= 8'h30;
        wb(`MPPC_U_DATA, 1, 8'ha5);
        rdc(`MPPC_U_DATA, 8'h35, "data mix");
        `CK("gpio oe", 8'h0f, uoe)
        wb(`MPPC_U_SLEW_LIMIT, 1, 8'hc0);
        rdc(`MPPC_U_DATA, 8'hf5, "data slew");
        wb(`MPPC_U_PIN_LEVEL, 1, 8'h00);
        rdc(`MPPC_U_PIN_LEVEL, 8'hf5, "pin level");
        `CK("inbuf", 8'h3f, uib)
        `CK("slew on", 8'hc0, usl)
        wb(`MPPC_U_PULL_ENABLE, 1, 8'hff);
        wb(`MPPC_U_PULL_POLARITY, 1, 8'h10);
        `CK("pull on", 8'hf0, upo)
        `CK("pull dn", 8'h10, upo & upd)
        wb(`MPPC_T_DIRECTION, 1, 8'h0f);
        wb(`MPPC_T_DRIVE_STRENGTH, 1, 8'hff);
        wb(`MPPC_T_PULL_ENABLE, 1, 8'hff);
        wb(`MPPC_T_PULL_POLARITY, 1, 8'hff);
        `CK("t drive", 8'h0f, tr)
        `CK("t pull", 8'hf0, tpo & tpd)
        rdc(8'h28, 8'h0, "unmapped");
        pwm <= 8'hff;
        up <= 8'h96;
        us <= 8'h5a;
        vp <= 8'h03;
        vs <= 8'hc0;
        xe <= 8'h0;
        repeat (2) @(posedge clk);
        `CK("pwm own", 8'h96, uo)
        sd <= 4'hb;
        repeat (2) @(posedge clk);
        `CK("u own", 8'h5a, uo)
        `CK("v own", 8'hc3, vo)
        `CK("v oe", 8'hff, voe)
        `CK("v pull", 8'h0, vpu)
        results();
    end
endmodule
`default_nettype wire
